/* File: clc_top.sv */
// Four configurable logic cells behind an AHB-Lite register slave
`include "clc_regs.svh"
// What this block does
// RL1: One read-only mirror register shows all cell outputs sampled together.
// RL2: Any reset clears each control register; selections and gating stay.
// RL3: Cell logic runs from its inputs, not dependent on processor activity.
// RL4: Enabled cell selecting fast oscillator keeps that oscillator running in sleep.
// RL5: Enable bit 7 lets the cell combine inputs; cleared forces output zero.
// RL6: Control bit 5 reads final cell output; writes to it are ignored.
// RL7: Control bit 4 lets rising output edges set the cell flag.
// RL8: Control bit 3 lets falling output edges set the cell flag.
// RL9: Function codes 000 to 011: AND-OR, OR-XOR, four-input AND, SR latch.
// RL10: Code 100 is D flip-flop with set/reset; 101 two-input D with reset.
// RL11: Code 110 is J-K flip-flop with reset; 111 transparent latch.
// RL12: Polarity bit 7 inverts the function result before the cell output.
// RL13: Polarity bits 3 to 0 invert gates 4 to 1 before the function.
// RL14: Control bit 6, polarity bits 6-4, select bits 7-6 read zero.
// RL15: Select register bits 5 to 0 choose the source for each data input.
// RL16: Selections and gating start undefined; control and output polarity reset zero.
// RL17: Each gate ANDs its enabled inputs; no enabled input gives zero.
// RL18: Software clears the flag; an edge during the clear keeps it set.
// RL19: Gate select bits: data 4 true at bit 7 down to data 1 negated.
// RL20: Source codes 0 to 40 each pick one distinct source signal.
// RL21: All four cells are identical with their own registers and edge logic.
module clc_top
    import clc_pkg::*;
(
    input  wire logic                 CLK_I,
    input  wire logic                 RST_N_I,
    input  wire logic                 HSEL_I,
    input  wire logic [31:0]          HADDR_I,
    input  wire logic [1:0]           HTRANS_I,
    input  wire logic                 HWRITE_I,
    input  wire logic [2:0]           HSIZE_I,
    input  wire logic [31:0]          HWDATA_I,
    input  wire logic                 HREADY_I,
    input  wire logic [`NUM_SRC-1:0]  SRC_I,
    output logic [31:0]               HRDATA_O,
    output logic                      HREADYOUT_O,
    output logic                      HRESP_O,
    output logic [`NUM_CELLS-1:0]     CELL_OUT_O,
    output logic [`NUM_CELLS-1:0]     CELL_IRQ_FLAG_O,
    output logic                      FAST_OSC_KEEP_O
);
    cell_cfg_s [`NUM_CELLS-1:0]  cfg;
    byte_t     [`NUM_CELLS-1:0]  ctrl_q;
    logic      [`NUM_CELLS-1:0]  out_pol_q;
    byte_t     [`NUM_CELLS-1:0]  gate_pol_q;
    byte_t     [`NUM_CELLS-1:0]  [3:0] sel_q;
    byte_t     [`NUM_CELLS-1:0]  [3:0] gls_q;
    logic      [`NUM_CELLS-1:0]  cell_out;
    logic      [`NUM_CELLS-1:0]  out_q;
    logic      [`NUM_CELLS-1:0]  flag_clr;
    logic      [`NUM_CELLS-1:0]  [3:0] cell_data;
    logic      [`NUM_SRC-1:0]    src_all;
    logic                        addr_phase;
    logic                        wr_q;
    logic      [`ADDR_MSB:0]     waddr_q;
    logic      [31:0]            rdata_d;
    logic                        keep_d;

    function automatic logic pick_src(input byte_t sel, input logic [`NUM_SRC-1:0] s);
        pick_src = 1'b0;
        if (sel[`SEL_MSB:0] <= `SRC_LAST_CODE) begin
            pick_src = s[sel[`SEL_MSB:0]]; // RL20
        end
    endfunction

    function automatic logic is_cell(input logic [`ADDR_MSB:0] a);
        is_cell = (a[`ADDR_MSB:`CELL_IDX_MSB] == '0)
                && (a[`WORD_IDX_MSB:`WORD_IDX_LSB] <= `IDX_LAST);
    endfunction

    function automatic logic [1:0] cell_of(input logic [`ADDR_MSB:0] a);
        cell_of = a[`CELL_IDX_MSB-1:`CELL_IDX_LSB];
    endfunction

    function automatic logic [3:0] word_of(input logic [`ADDR_MSB:0] a);
        word_of = a[`WORD_IDX_MSB:`WORD_IDX_LSB];
    endfunction

    // Feedback of the cell outputs takes the place of source codes 4 to 7
    assign src_all = {SRC_I[`NUM_SRC-1:`SRC_FB_MSB+1], out_q, SRC_I[`SRC_FB_LSB-1:0]};

    always_comb begin
        for (int c = 0; c < `NUM_CELLS; c++) begin
            for (int k = 0; k < 4; k++) begin
                cell_data[c][k] = pick_src(sel_q[c][k], src_all); // RL15
            end
            cfg[c].ctrl = ctrl_q[c];
            cfg[c].pol  = {out_pol_q[c], 3'h0, gate_pol_q[c][`POL_GATE_MSB:0]};
            cfg[c].sel  = sel_q[c];
            cfg[c].gls  = gls_q[c];
        end
    end

    // Identical cells, each with private registers and edge logic
    for (genvar c = 0; c < `NUM_CELLS; c++) begin : g_cell
        logic_cell_core u_core (
            .clk_i   (CLK_I),
            .rst_n_i (RST_N_I),
            .cfg_i   (cfg[c]),
            .data_i  (cell_data[c]),
            .out_o   (cell_out[c])
        ); // RL21 RL3
        edge_flag u_flag (
            .clk_i     (CLK_I),
            .rst_n_i   (RST_N_I),
            .out_i     (out_q[c]),
            .rise_en_i (ctrl_q[c][`CTRL_RISE_BIT]),
            .fall_en_i (ctrl_q[c][`CTRL_FALL_BIT]),
            .clear_i   (flag_clr[c]),
            .flag_o    (CELL_IRQ_FLAG_O[c])
        ); // RL21
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            out_q <= '0;
        end else begin
            out_q <= cell_out;
        end
    end

    assign CELL_OUT_O = out_q;

    // Bus address phase and data phase capture
    assign addr_phase = HSEL_I & HTRANS_I[1] & HREADY_I;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            wr_q    <= 1'b0;
            waddr_q <= '0;
        end else if (HREADY_I) begin
            wr_q    <= addr_phase & HWRITE_I;
            waddr_q <= HADDR_I[`ADDR_MSB:0];
        end
    end

    // Write-one-to-clear of the flags register
    always_comb begin
        flag_clr = '0;
        if (wr_q && waddr_q == `FLAG_ADDR) begin
            flag_clr = HWDATA_I[`NUM_CELLS-1:0]; // RL18
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ctrl_q    <= {`NUM_CELLS{`CTRL_RST}}; // RL2 RL16
            out_pol_q <= {`NUM_CELLS{`POL_OUT_RST}};
        end else if (wr_q && is_cell(waddr_q)) begin
            if (word_of(waddr_q) == `IDX_CTRL) begin
                ctrl_q[cell_of(waddr_q)] <= HWDATA_I[7:0] & `CTRL_WR_MASK; // RL6 RL14
            end else if (word_of(waddr_q) == `IDX_POL) begin
                out_pol_q[cell_of(waddr_q)] <= HWDATA_I[`POL_OUT_BIT];
            end
        end
    end

    // No reset: selections and gating keep their value over a reset
    always_ff @(posedge CLK_I) begin
        if (wr_q && is_cell(waddr_q)) begin
            if (word_of(waddr_q) == `IDX_POL) begin
                gate_pol_q[cell_of(waddr_q)] <= HWDATA_I[7:0] & `POL_WR_MASK;
            end else if (word_of(waddr_q) >= `IDX_GLS_BASE) begin
                gls_q[cell_of(waddr_q)][2'(word_of(waddr_q) - `IDX_GLS_BASE)] <= HWDATA_I[7:0];
            end else if (word_of(waddr_q) >= `IDX_SEL_BASE) begin
                sel_q[cell_of(waddr_q)][2'(word_of(waddr_q) - `IDX_SEL_BASE)] <=
                    HWDATA_I[7:0] & `SEL_WR_MASK; // RL14
            end
        end
    end

    // Read data chosen in the address phase, so the answer needs no wait state
    always_comb begin
        rdata_d = '0;
        if (HADDR_I[`ADDR_MSB:0] == `MIRROR_ADDR) begin
            rdata_d[`NUM_CELLS-1:0] = out_q; // RL1
        end else if (HADDR_I[`ADDR_MSB:0] == `FLAG_ADDR) begin
            rdata_d[`NUM_CELLS-1:0] = CELL_IRQ_FLAG_O;
        end else if (is_cell(HADDR_I[`ADDR_MSB:0])) begin
            if (word_of(HADDR_I[`ADDR_MSB:0]) == `IDX_CTRL) begin
                rdata_d[7:0] = ctrl_q[cell_of(HADDR_I[`ADDR_MSB:0])];
                rdata_d[`CTRL_OUT_BIT] = out_q[cell_of(HADDR_I[`ADDR_MSB:0])]; // RL6
            end else begin
                rdata_d[7:0] = cfg[cell_of(HADDR_I[`ADDR_MSB:0])].pol; // RL14
                if (word_of(HADDR_I[`ADDR_MSB:0]) >= `IDX_GLS_BASE) begin
                    rdata_d[7:0] = gls_q[cell_of(HADDR_I[`ADDR_MSB:0])]
                        [2'(word_of(HADDR_I[`ADDR_MSB:0]) - `IDX_GLS_BASE)];
                end else if (word_of(HADDR_I[`ADDR_MSB:0]) >= `IDX_SEL_BASE) begin
                    rdata_d[7:0] = sel_q[cell_of(HADDR_I[`ADDR_MSB:0])]
                        [2'(word_of(HADDR_I[`ADDR_MSB:0]) - `IDX_SEL_BASE)];
                end
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            HRDATA_O <= '0;
        end else if (addr_phase && !HWRITE_I) begin
            HRDATA_O <= rdata_d;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            HREADYOUT_O <= 1'b0;
            HRESP_O     <= `HRESP_OKAY;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= `HRESP_OKAY;
        end
    end

    // Oscillator keep-alive request for sleep
    always_comb begin
        keep_d = 1'b0;
        for (int c = 0; c < `NUM_CELLS; c++) begin
            for (int k = 0; k < 4; k++) begin
                if (ctrl_q[c][`CTRL_EN_BIT] && sel_q[c][k][`SEL_MSB:0] == `SRC_FAST_OSC) begin
                    keep_d = 1'b1; // RL4
                end
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            FAST_OSC_KEEP_O <= 1'b0;
        end else begin
            FAST_OSC_KEEP_O <= keep_d;
        end
    end

    AST_MIRROR_READ: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RL1
        addr_phase && !HWRITE_I && HADDR_I[`ADDR_MSB:0] == `MIRROR_ADDR
        |=> HRDATA_O[`NUM_CELLS-1:0] == $past(out_q) && HRDATA_O[31:`NUM_CELLS] == '0)
        else $error("mirror read does not match cell outputs");

    AST_CTRL_CLEARED: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RL2
        $rose(RST_N_I) |-> ctrl_q == '0 && out_pol_q == '0)
        else $error("control not cleared by reset");

    AST_DISABLED_LOW: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RL5
        !ctrl_q[0][`CTRL_EN_BIT] |=> !out_q[0])
        else $error("disabled cell drives a one");

    AST_OUT_BIT_READ: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RL6
        addr_phase && !HWRITE_I && HADDR_I[`ADDR_MSB:0] == 12'h000
        |=> HRDATA_O[`CTRL_OUT_BIT] == $past(out_q[0]) && HRDATA_O[6] == 1'b0)
        else $error("control output bit wrong");

    AST_RISE_SETS: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RL7
        $rose(out_q[0]) && ctrl_q[0][`CTRL_RISE_BIT] |=> CELL_IRQ_FLAG_O[0])
        else $error("rising edge did not set flag");

    AST_FALL_SETS: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RL8
        $fell(out_q[0]) && ctrl_q[0][`CTRL_FALL_BIT] |=> CELL_IRQ_FLAG_O[0])
        else $error("falling edge did not set flag");

    AST_QUIET_NO_SET: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RL7
        !CELL_IRQ_FLAG_O[0] && $stable(out_q[0]) |=> !CELL_IRQ_FLAG_O[0])
        else $error("flag set without an edge");

    AST_POL_ZERO_BITS: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RL14
        addr_phase && !HWRITE_I && HADDR_I[`ADDR_MSB:0] == 12'h004
        |=> HRDATA_O[6:4] == 3'h0 && HRDATA_O[31:8] == '0)
        else $error("unimplemented polarity bits read nonzero");

    AST_CLEAR_LOSES: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RL18
        flag_clr[0] && $rose(out_q[0]) && ctrl_q[0][`CTRL_RISE_BIT] |=> CELL_IRQ_FLAG_O[0])
        else $error("edge lost during flag clear");

    AST_OSC_KEEP: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // RL4
        ctrl_q[1][`CTRL_EN_BIT] && sel_q[1][0][`SEL_MSB:0] == `SRC_FAST_OSC
        |=> FAST_OSC_KEEP_O)
        else $error("fast oscillator not kept alive");

    AST_BUS_OKAY: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        $past(RST_N_I) |-> HREADYOUT_O && HRESP_O == `HRESP_OKAY)
        else $error("slave stalled or answered an error");

endmodule

/* File: clc_regs.svh */
// Register offsets, field positions and reset values of the logic cell block
`ifndef CLC_REGS_SVH
`define CLC_REGS_SVH

`define NUM_CELLS        4
`define NUM_SRC          41
`define ADDR_MSB         11
`define CELL_IDX_MSB     8
`define CELL_IDX_LSB     6
`define WORD_IDX_MSB     5
`define WORD_IDX_LSB     2
`define IDX_CTRL         4'h0
`define IDX_POL          4'h1
`define IDX_SEL_BASE     4'h2
`define IDX_GLS_BASE     4'h6
`define IDX_LAST         4'h9
`define MIRROR_ADDR      12'h100
`define FLAG_ADDR        12'h104

`define CTRL_EN_BIT      7
`define CTRL_OUT_BIT     5
`define CTRL_RISE_BIT    4
`define CTRL_FALL_BIT    3
`define CTRL_MODE_MSB    2
`define CTRL_WR_MASK     8'h9F
`define CTRL_RST         8'h00
`define POL_OUT_BIT      7
`define POL_GATE_MSB     3
`define POL_WR_MASK      8'h8F
`define POL_OUT_RST      1'b0
`define SEL_MSB          5
`define SEL_WR_MASK      8'h3F
`define SRC_LAST_CODE    6'h28
`define SRC_FAST_OSC     6'h20
`define SRC_FB_LSB       4
`define SRC_FB_MSB       7
`define HTRANS_NONSEQ    2'b10
`define HRESP_OKAY       1'b0

`endif

/* File: clc_pkg.sv */
// Types shared by the logic cell block
package clc_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [2:0] {
        MODE_AND_OR  = 3'h0,
        MODE_OR_XOR  = 3'h1,
        MODE_AND4    = 3'h2,
        MODE_SR      = 3'h3,
        MODE_DFF_SR  = 3'h4,
        MODE_DFF_R   = 3'h5,
        MODE_JK_R    = 3'h6,
        MODE_LATCH   = 3'h7
    } mode_e;

    typedef struct packed {
        byte_t       ctrl;
        byte_t       pol;
        byte_t [3:0] sel;
        byte_t [3:0] gls;
    } cell_cfg_s;

endpackage

/* File: logic_cell_core.sv */
// Gating, logic function, storage and output polarity of one cell
`include "clc_regs.svh"
module logic_cell_core
    import clc_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    input  wire cell_cfg_s cfg_i,
    input  wire logic [3:0] data_i,
    output logic           out_o
);
    logic [3:0] g;
    logic       g1_prev_q;
    logic       state_q;
    logic       state_d;
    logic       rise1;
    logic       func;
    logic       en;
    mode_e      mode;

    function automatic logic gate_and(input byte_t ls, input logic [3:0] d);
        byte_t t;
        t = {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]};
        gate_and = (|ls) & (&(t | ~ls)); // RL17
    endfunction

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            g[k] = gate_and(cfg_i.gls[k], data_i) ^ cfg_i.pol[k]; // RL13 RL19
        end
    end

    assign en    = cfg_i.ctrl[`CTRL_EN_BIT];
    assign mode  = mode_e'(cfg_i.ctrl[`CTRL_MODE_MSB:0]);
    // Storage clocks on gate 1; sampled edge keeps one clock domain
    assign rise1 = g[0] & ~g1_prev_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            g1_prev_q <= 1'b0;
        end else begin
            g1_prev_q <= g[0];
        end
    end

    always_comb begin
        state_d = state_q;
        case (mode)
            MODE_SR: begin
                if (g[0] | g[1]) begin
                    state_d = 1'b1;
                end else if (g[2] | g[3]) begin
                    state_d = 1'b0;
                end
            end
            MODE_DFF_SR: begin
                if (g[2]) begin
                    state_d = 1'b0;
                end else if (g[3]) begin
                    state_d = 1'b1;
                end else if (rise1) begin
                    state_d = g[1];
                end
            end
            MODE_DFF_R: begin
                if (g[2]) begin
                    state_d = 1'b0;
                end else if (rise1) begin
                    state_d = g[1] & g[3];
                end
            end
            MODE_JK_R: begin
                if (g[2]) begin
                    state_d = 1'b0;
                end else if (rise1) begin
                    state_d = (g[1] & ~state_q) | (~g[3] & state_q);
                end
            end
            MODE_LATCH: begin
                if (g[2]) begin
                    state_d = 1'b0;
                end else if (g[3]) begin
                    state_d = 1'b1;
                end else if (g[0]) begin
                    state_d = g[1];
                end
            end
            default: begin
                state_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !en) begin
            state_q <= 1'b0;
        end else begin
            state_q <= state_d; // RL10 RL11
        end
    end

    always_comb begin
        case (mode)
            MODE_AND_OR: func = (g[0] & g[1]) | (g[2] & g[3]); // RL9
            MODE_OR_XOR: func = (g[0] | g[1]) ^ (g[2] | g[3]);
            MODE_AND4:   func = &g;
            MODE_LATCH:  func = state_d;
            default:     func = state_q;
        endcase
    end

    assign out_o = en & (func ^ cfg_i.pol[`POL_OUT_BIT]); // RL5 RL12

endmodule

/* File: edge_flag.sv */
// Rising and falling edge detection and sticky flag of one cell
module edge_flag (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic out_i,
    input  wire logic rise_en_i,
    input  wire logic fall_en_i,
    input  wire logic clear_i,
    output logic      flag_o
);
    logic prev_q;
    logic hit;

    assign hit = (rise_en_i & out_i & ~prev_q) // RL7
               | (fall_en_i & ~out_i & prev_q); // RL8

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= out_i;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flag_o <= 1'b0;
        end else if (hit) begin
            flag_o <= 1'b1; // RL18
        end else if (clear_i) begin
            flag_o <= 1'b0;
        end
    end

endmodule

/* File: clc_src_model.sv */
// Far-side source model: test pattern on codes 0 to 3, free-running toggles elsewhere
`include "clc_regs.svh"
module clc_src_model (
    input  wire logic           clk_i,
    input  wire logic [3:0]     pat_i,
    output logic [`NUM_SRC-1:0] src_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog_q = 1'b0;
    // Oscillators and timers never stop, so every other source toggles each cycle
    always @(posedge clk_i) begin
        tog_q <= ~tog_q;
    end
    assign src_o = {{(`NUM_SRC - 4){tog_q}}, pat_i};
endmodule

/* File: clc_top_tb.sv */
// Self-checking bench for the four-cell logic block
`include "clc_regs.svh"
module clc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = 3;
    logic                clk, rst_n, hsel, hwrite, hready, hresp, osc_keep;
    logic [31:0]         haddr, hwdata, hrdata;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [3:0]          pat, cell_out, irq_flag;
    logic [`NUM_SRC-1:0] src;
    int                  err_count, compares;

    clc_top clc_top_i (
        .CLK_I           (clk),
        .RST_N_I         (rst_n),
        .HSEL_I          (hsel),
        .HADDR_I         (haddr),
        .HTRANS_I        (htrans),
        .HWRITE_I        (hwrite),
        .HSIZE_I         (hsize),
        .HWDATA_I        (hwdata),
        .HREADY_I        (hready),
        .SRC_I           (src),
        .HRDATA_O        (hrdata),
        .HREADYOUT_O     (hready),
        .HRESP_O         (hresp),
        .CELL_OUT_O      (cell_out),
        .CELL_IRQ_FLAG_O (irq_flag),
        .FAST_OSC_KEEP_O (osc_keep)
    );

    clc_src_model clc_src_model_i (
        .clk_i (clk),
        .pat_i (pat),
        .src_o (src)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait for hready; a hang ends the run
    task automatic wait_edge();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        if (hready !== 1'b1) begin
            err_count++;
            print_verdict();
        end
    endtask

    // Pattern change in p rides on the address phase, for the clear-collision case
    task automatic xfer(input logic wr_en, input logic [11:0] a, input logic [7:0] d,
                        output logic [31:0] q, input logic [4:0] p);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= `HTRANS_NONSEQ;
        haddr <= {20'h0_0000, a};
        hwrite <= wr_en;
        if (p[4]) begin
            pat <= p[3:0];
        end
        wait_edge();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        wait_edge();
        q = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [4:0] p = 5'h00);
        logic [31:0] q;
        xfer(1'b1, a, d, q, p);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        xfer(1'b0, a, 8'h00, q, 5'h00);
        chk(what, exp, q);
    endtask

    task automatic set_pat(input logic [3:0] p);
        @(posedge clk);
        pat <= p;
        repeat (SETTLE) @(posedge clk);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wait_edge();
    endtask

    function automatic logic [11:0] ra(input int c, input int k);
        ra = 12'(c * 64 + k * 4);
    endfunction

    function automatic logic comb(input logic [2:0] m, input logic [7:0] pv, input logic [3:0] d);
        logic [3:0] g;
        g = d ^ pv[3:0];
        case (m)
            3'h0: comb = (g[0] & g[1]) | (g[2] & g[3]);
            3'h1: comb = (g[0] | g[1]) ^ (g[2] | g[3]);
            default: comb = &g;
        endcase
        comb = comb ^ pv[7];
    endfunction

    // Data k from source k, gate k takes data k true
    task automatic cfg(input int c);
        for (int k = 0; k < 4; k++) begin
            wr(ra(c, 2 + k), 8'(k));
            wr(ra(c, 6 + k), 8'(2 << (2 * k)));
        end
    endtask

    task automatic t_reset();
        for (int c = 0; c < 4; c++) begin
            rdchk(ra(c, 0), 32'h0000_0000, "ctrl");
        end
        chk("outs", 32'h0000_0000, {28'h0, cell_out});
        chk("flags", 32'h0000_0000, {28'h0, irq_flag});
        chk("osc keep", 32'h0000_0000, {31'h0, osc_keep});
        $display("t_reset done");
    endtask

    task automatic t_access();
        wr(ra(2, 0), 8'h7F);
        rdchk(ra(2, 0), 32'h0000_001F, "ctrl bits");
        wr(ra(2, 1), 8'hFF);
        rdchk(ra(2, 1), 32'h0000_008F, "pol bits");
        wr(ra(2, 2), 8'hFF);
        rdchk(ra(2, 2), 32'h0000_003F, "sel bits");
        wr(ra(2, 9), 8'h5A);
        rdchk(ra(2, 9), 32'h0000_005A, "gate sel");
        wr(12'h03C, 8'hFF);
        rdchk(12'h03C, 32'h0000_0000, "unmapped");
        wr(`MIRROR_ADDR, 8'h0F);
        rdchk(`MIRROR_ADDR, 32'h0000_0000, "mirror ro");
        wr(ra(2, 0), 8'h00);
        $display("t_access done");
    endtask

    task automatic t_func(input int c);
        logic [7:0] pv;
        cfg(c);
        for (int m = 0; m < 3; m++) begin
            for (int i = 0; i < 2; i++) begin
                pv = (i == 0) ? 8'h00 : 8'h8F;
                wr(ra(c, 1), pv);
                wr(ra(c, 0), 8'h80 | 8'(m));
                for (int d = 0; d < 16; d++) begin
                    set_pat(4'(d));
                    chk("func", {31'h0, comb(3'(m), pv, 4'(d))}, {31'h0, cell_out[c]});
                end
            end
        end
        rdchk(`MIRROR_ADDR, 32'(1 << c), "mirror");
        rdchk(ra(c, 0), 32'h0000_00A2, "ctrl out");
        for (int k = 0; k < 4; k++) begin
            wr(ra(c, 6 + k), 8'h00);
        end
        wr(ra(c, 1), 8'h0F);
        set_pat(4'h0);
        chk("empty gates", 32'h0000_0001, {31'h0, cell_out[c]});
        wr(ra(c, 0), 8'h00);
        set_pat(4'h0);
        chk("disabled", 32'h0000_0000, {31'h0, cell_out[c]});
        $display("t_func done");
    endtask

    // Each byte is {exp, pattern}, first step in the top byte
    task automatic t_seq();
        logic [63:0] tbl [5];
        logic [7:0]  s;
        tbl = '{64'h0011_1004_0015_0800, 64'h0002_1312_1001_180C, 64'h0002_030A_1B1A_0E00,
                64'h000A_1B1A_0B02_1307, 64'h1301_0002_1810_0413};
        cfg(0);
        wr(ra(0, 1), 8'h00);
        for (int m = 3; m < 8; m++) begin
            set_pat(4'h0);
            wr(ra(0, 0), 8'h00);
            wr(ra(0, 0), 8'h80 | 8'(m));
            for (int i = 0; i < 8; i++) begin
                s = tbl[m - 3][63 - 8 * i -: 8];
                set_pat(s[3:0]);
                chk("storage", {31'h0, s[4]}, {31'h0, cell_out[0]});
            end
        end
        wr(ra(0, 0), 8'h00);
        $display("t_seq done");
    endtask

    task automatic t_irq();
        set_pat(4'h0);
        wr(ra(0, 0), 8'h90);
        wr(`FLAG_ADDR, 8'h0F);
        set_pat(4'h3);
        chk("rise flag", 32'h0000_0001, {28'h0, irq_flag});
        rdchk(`FLAG_ADDR, 32'h0000_0001, "flag reg");
        wr(`FLAG_ADDR, 8'h01);
        rdchk(`FLAG_ADDR, 32'h0000_0000, "flag clear");
        set_pat(4'h0);
        chk("fall off", 32'h0000_0000, {28'h0, irq_flag});
        wr(ra(0, 0), 8'h88);
        set_pat(4'h3);
        chk("rise off", 32'h0000_0000, {28'h0, irq_flag});
        set_pat(4'h0);
        chk("fall flag", 32'h0000_0001, {28'h0, irq_flag});
        wr(ra(0, 0), 8'h98);
        wr(`FLAG_ADDR, 8'h01, 5'h13);
        repeat (SETTLE) @(posedge clk);
        chk("clear race", 32'h0000_0001, {28'h0, irq_flag});
        wr(ra(0, 0), 8'h00);
        wr(`FLAG_ADDR, 8'h0F);
        $display("t_irq done");
    endtask

    task automatic t_osc();
        for (int k = 0; k < 4; k++) begin
            wr(ra(1, 2 + k), (k == 0) ? 8'(`SRC_FAST_OSC) : 8'h00);
            wr(ra(1, 6 + k), 8'h00);
        end
        wr(ra(1, 1), 8'h00);
        wr(ra(1, 0), 8'h80);
        set_pat(4'h0);
        chk("osc on", 32'h0000_0001, {31'h0, osc_keep});
        wr(ra(1, 0), 8'h00);
        set_pat(4'h0);
        chk("osc off", 32'h0000_0000, {31'h0, osc_keep});
        wr(ra(1, 2), 8'h21);
        wr(ra(1, 0), 8'h80);
        set_pat(4'h0);
        chk("osc other", 32'h0000_0000, {31'h0, osc_keep});
        wr(ra(1, 0), 8'h00);
        $display("t_osc done");
    endtask

    task automatic t_rst2();
        wr(ra(0, 2), 8'h15);
        wr(ra(0, 1), 8'h8F);
        wr(ra(0, 0), 8'h9A);
        do_reset();
        rdchk(ra(0, 0), 32'h0000_0000, "ctrl rst");
        rdchk(ra(0, 2), 32'h0000_0015, "sel kept");
        rdchk(ra(0, 1), 32'h0000_000F, "pol rst");
        $display("t_rst2 done");
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial begin
        err_count = 0;
        compares = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        pat = 4'h0;
        do_reset();
        t_reset();
        t_access();
        t_func(0);
        t_func(3);
        t_seq();
        t_irq();
        t_osc();
        t_rst2();
        print_verdict();
    end
endmodule
